//--- core/dcg_map.vh
// register map, field positions and reset values of the clock controller
`ifndef DCG_MAP_VH
`define DCG_MAP_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DCG_ADDR_WDHALT 8'h5C
`define DCG_ADDR_CKOUT 8'h6D
`define DCG_ADDR_OSC 8'h6E
`define DCG_ADDR_GEAR 8'h6F

// ------------------------------------------------------------
// oscillator_control fields
// ------------------------------------------------------------
`define DCG_OSC_HI_EN 7
`define DCG_OSC_LO_EN 6
`define DCG_OSC_HI_AS 5
`define DCG_OSC_LO_AS 4
`define DCG_OSC_SRC_AS 3
`define DCG_OSC_WUF 2
`define DCG_OSC_PRE_HI 1
`define DCG_OSC_PRE_LO 0

// ------------------------------------------------------------
// gear_source_select fields
// ------------------------------------------------------------
`define DCG_GEAR_SRC 3
`define DCG_GEAR_HI 2
`define DCG_GEAR_LO 0
`define DCG_GEAR_FILL 4'hF

// ------------------------------------------------------------
// clock_output_control fields
// ------------------------------------------------------------
`define DCG_CK_CLKOUT_SOURCE_SELECT 3
`define DCG_CK_CLKOUT_ENABLE 2
`define DCG_CK_LATCH_STROBE_ENABLE 1
`define DCG_CK_CLKEN 0

// ------------------------------------------------------------
// watchdog_halt_mode fields
// ------------------------------------------------------------
`define DCG_WD_EN 7
`define DCG_WD_PER_HI 6
`define DCG_WD_PER_LO 5
`define DCG_WD_WARM 4
`define DCG_WD_HALT_HI 3
`define DCG_WD_HALT_LO 2
`define DCG_WD_RSTLNK 1
`define DCG_WD_DRV 0

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define DCG_RST_OSC 8'hA0
`define DCG_RST_GEAR 4'h4
`define DCG_RST_CK 4'h0
`define DCG_RST_WD 8'h80
`define DCG_GEAR_MAX 3'h4
`define DCG_PRE_RSVD 2'h3
`define DCG_HM_RUN 2'h0
`define DCG_HM_STOP 2'h1
`define DCG_HM_DEEP_IDLE 2'h2
`define DCG_HM_LIGHT_IDLE 2'h3
`define DCG_FC16_EDGES 5'h10
`define DCG_WARM_SHORT 17'h04000
`define DCG_WARM_LONG 17'h10000

`endif

//--- core/dcg_ctrl.v
// dual oscillator clock gear, warm-up timer and standby controller
`timescale 1ns/1ns
`include "dcg_map.vh"
// Summary of operation
// - reset: high osc on, low osc off, high source, gear divide by 16.
// - state clock is the geared base clock halved.
// - source select bit 3 at 0x6F: 0 high osc, 1 low osc.
// - gear codes 000..100 divide high clock by 1,2,4,8,16.
// - oscillator enable bits: 0 stop, 1 run; high resets 1, low 0.
// - the oscillator that is the selected source runs except in STOP.
// - after-stop enables choose oscillators after STOP; reset 1 and 0.
// - after-stop source bit picks base source on leaving STOP.
// - write 1 starts warm-up, 0 ignored; reads 1 while busy.
// - warm-up length 2^14 periods when 0, 2^16 when 1.
// - warm-up counts periods of the oscillator being waited on.
// - prescaler source 00 base, 01 low clock, 10 fc/16; resets 00.
// - clock-out select: 0 base clock, 1 state clock; own enable.
// - output control holds three enables, all reset to 0.
// - clock pin carries the state clock divided by two.
// - during reset clock pin driven high, latch strobe pin released.
// - halt field: 00 RUN, 01 STOP, 10 deep idle, 11 light idle.
// - deep idle keeps osc and rtc; light idle stops adc; STOP all.
// - watchdog enable bit: 0 disable, 1 enable; resets 1.
// - upper four bits of gear register read as 1.
// - gear acts only while the high oscillator is the source.

module dcg_ctrl #(
   parameter [16:0] WARM_SHORT = `DCG_WARM_SHORT, // short warm-up periods
   parameter [16:0] WARM_LONG = `DCG_WARM_LONG // long warm-up periods
) (
   input wire mclk, // system clock, 25 MHz
   input wire rst, // async reset, active high
   input wire [7:0] addr, // register address
   input wire [7:0] wr_data, // register write data
   input wire wr_en, // write strobe
   input wire rd_en, // read strobe
   output reg [7:0] rd_data, // read data, cycle after rd_en
   input wire fc_pin, // high-frequency oscillator clock
   input wire fs_pin, // low-frequency oscillator clock
   input wire halt_req, // halt instruction pulse
   input wire halt_release, // halt release pulse
   input wire ale_src, // latch strobe from the bus unit
   output reg hi_osc_run, // high oscillator enable
   output reg lo_osc_run, // low oscillator enable
   output reg base_clk, // geared base clock
   output reg state_clk, // state clock
   output reg presc_clk, // prescaler input clock
   output reg system_clock_out_pin, // clock-out pin value
   output reg system_clock_out_pin_oe, // clock-out pin enable
   output reg clk_pin_o, // clock pin value
   output reg clk_pin_oe, // clock pin enable
   output reg ale_o, // latch strobe pin value
   output reg ale_oe, // latch strobe pin enable
   output reg cpu_halted, // cpu stopped by halt
   output reg io_stop, // internal i/o stopped
   output reg adc_stop, // converter stopped
   output reg rtc_stop, // real-time clock timer stopped
   output reg watchdog_enable, // watchdog enable
   output reg [1:0] watchdog_period, // watchdog period code
   output reg watchdog_to_reset_link, // watchdog drives reset
   output reg drive_in_stop // pin drive kept in STOP
);

   // ------------------------------------------------------------
   // halt states, one-hot
   // ------------------------------------------------------------
   localparam [4:0] ST_NORMAL = 5'h01;
   localparam [4:0] ST_RUN = 5'h02;
   localparam [4:0] ST_LIGHT = 5'h04;
   localparam [4:0] ST_DEEP = 5'h08;
   localparam [4:0] ST_STOP = 5'h10;

   reg [7:0] osc_r;
   reg [3:0] gear_r;
   reg [3:0] ck_r;
   reg [7:0] wd_r;
   reg [4:0] st_r;
   reg [4:0] st_nxt;
   reg fc_s1, fc_s2, fc_s3;
   reg fs_s1, fs_s2, fs_s3;
   reg act_src_r;
   reg [2:0] act_gear_r;
   reg [4:0] gcnt_r;
   reg skip_r;
   reg [4:0] f16_r;
   reg fc16_r;
   reg [16:0] wcnt_r;
   reg wbusy_r;
   reg clkout_r;
   reg [4:0] div_lim;
   wire fc_edge, fs_edge, fc_rise, fs_rise;
   wire src_edge, fpph_tick, fsys_rise, wu_rise, wu_done;
   wire wr_osc, wr_gear, wr_ck, wr_wd, in_stop;
   wire [16:0] wu_len;

   assign wr_osc = wr_en & (addr == `DCG_ADDR_OSC);
   assign wr_gear = wr_en & (addr == `DCG_ADDR_GEAR);
   assign wr_ck = wr_en & (addr == `DCG_ADDR_CKOUT);
   assign wr_wd = wr_en & (addr == `DCG_ADDR_WDHALT);
   assign in_stop = st_r[4];

   // ------------------------------------------------------------
   // oscillator pin synchronisers and edge detect
   // ------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         fc_s1 <= 1'b0;
         fc_s2 <= 1'b0;
         fc_s3 <= 1'b0;
         fs_s1 <= 1'b0;
         fs_s2 <= 1'b0;
         fs_s3 <= 1'b0;
      end else begin
         fc_s1 <= fc_pin;
         fc_s2 <= fc_s1;
         fc_s3 <= fc_s2;
         fs_s1 <= fs_pin;
         fs_s2 <= fs_s1;
         fs_s3 <= fs_s2;
      end
   end

   // both edges count half periods; stopped oscillators give none
   assign fc_edge = (fc_s2 ^ fc_s3) & hi_osc_run;
   assign fs_edge = (fs_s2 ^ fs_s3) & lo_osc_run;
   assign fc_rise = fc_s2 & ~fc_s3 & hi_osc_run;
   assign fs_rise = fs_s2 & ~fs_s3 & lo_osc_run;

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         osc_r <= `DCG_RST_OSC;
         gear_r <= `DCG_RST_GEAR;
         ck_r <= `DCG_RST_CK;
         wd_r <= `DCG_RST_WD;
      end else begin
         if (wr_osc) begin
            osc_r[7:3] <= wr_data[7:3];
            if (wr_data[1:0] != `DCG_PRE_RSVD) begin
               osc_r[1:0] <= wr_data[1:0];
            end
         end else if (st_r[4] && halt_release) begin
            // leaving STOP loads the after-stop oscillator choice
            osc_r[7] <= osc_r[`DCG_OSC_HI_AS];
            osc_r[6] <= osc_r[`DCG_OSC_LO_AS];
         end
         if (wr_gear) begin
            gear_r[3] <= wr_data[`DCG_GEAR_SRC];
            if (wr_data[2:0] <= `DCG_GEAR_MAX) begin
               gear_r[2:0] <= wr_data[2:0];
            end
         end else if (st_r[4] && halt_release) begin
            gear_r[3] <= osc_r[`DCG_OSC_SRC_AS];
         end
         if (wr_ck) begin
            ck_r <= wr_data[3:0];
         end
         if (wr_wd) begin
            wd_r <= wr_data;
         end
      end
   end

   // ------------------------------------------------------------
   // read data, one cycle after the strobe
   // ------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            `DCG_ADDR_OSC: rd_data <= {osc_r[7:3], wbusy_r, osc_r[1:0]};
            // upper nibble always reads as ones
            `DCG_ADDR_GEAR: rd_data <= {`DCG_GEAR_FILL, gear_r};
            `DCG_ADDR_CKOUT: rd_data <= {4'h0, ck_r};
            `DCG_ADDR_WDHALT: rd_data <= wd_r;
            default: rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // oscillator enables
   // ------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         hi_osc_run <= 1'b1;
         lo_osc_run <= 1'b0;
      end else if (in_stop) begin
         hi_osc_run <= 1'b0;
         lo_osc_run <= 1'b0;
      end else begin
         // selected source runs whatever its enable says
         hi_osc_run <= osc_r[`DCG_OSC_HI_EN] | ~gear_r[3];
         lo_osc_run <= osc_r[`DCG_OSC_LO_EN] | gear_r[3];
      end
   end

   // ------------------------------------------------------------
   // gear divider and base clock
   // ------------------------------------------------------------
   assign src_edge = act_src_r ? fs_edge : fc_edge;
   assign fpph_tick = src_edge & ~skip_r & (gcnt_r == div_lim - 5'h01);

   // half-period edge count of the active gear
   always @* begin
      case (act_gear_r)
         3'h0: div_lim = 5'h01;
         3'h1: div_lim = 5'h02;
         3'h2: div_lim = 5'h04;
         3'h3: div_lim = 5'h08;
         default: div_lim = 5'h10;
      endcase
      if (act_src_r) begin
         div_lim = 5'h01;
      end
   end

   // new source and gear load at a falling base clock toggle, or on a source change while base clock is low
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         act_src_r <= 1'b0;
         act_gear_r <= `DCG_GEAR_MAX;
         gcnt_r <= 5'h00;
         skip_r <= 1'b0;
         base_clk <= 1'b0;
      end else if (fpph_tick || (act_src_r != gear_r[3] && !in_stop
                   && !(gear_r[3] ? lo_osc_run : hi_osc_run) == 1'b0
                   && gcnt_r == 5'h00 && !base_clk)) begin
         gcnt_r <= 5'h00;
         if (fpph_tick) begin
            base_clk <= ~base_clk;
         end
         if (base_clk || !fpph_tick) begin
            act_src_r <= gear_r[3];
            act_gear_r <= gear_r[2:0];
            // drop the new source's first edge so no runt phase follows
            skip_r <= (act_src_r != gear_r[3]) || (act_gear_r != gear_r[2:0]);
         end
      end else if (src_edge && skip_r) begin
         skip_r <= 1'b0;
      end else if (src_edge) begin
         gcnt_r <= gcnt_r + 5'h01;
      end
   end

   // ------------------------------------------------------------
   // state clock, clock pin divider, fc/16 clock
   // ------------------------------------------------------------
   assign fsys_rise = fpph_tick & ~base_clk;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_clk <= 1'b0;
         clkout_r <= 1'b0;
         f16_r <= 5'h00;
         fc16_r <= 1'b0;
      end else begin
         if (fsys_rise) begin
            state_clk <= ~state_clk;
            if (!state_clk) begin
               clkout_r <= ~clkout_r;
            end
         end
         if (fc_edge) begin
            if (f16_r == `DCG_FC16_EDGES - 5'h01) begin
               f16_r <= 5'h00;
               fc16_r <= ~fc16_r;
            end else begin
               f16_r <= f16_r + 5'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // prescaler source
   // ------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         presc_clk <= 1'b0;
      end else begin
         case (osc_r[1:0])
            2'h1: presc_clk <= fs_s2 & lo_osc_run;
            2'h2: presc_clk <= fc16_r;
            default: presc_clk <= base_clk;
         endcase
      end
   end

   // ------------------------------------------------------------
   // warm-up timer
   // ------------------------------------------------------------
   // waits on the oscillator that is not the current source
   assign wu_rise = gear_r[3] ? fc_rise : fs_rise;
   assign wu_len = wd_r[`DCG_WD_WARM] ? WARM_LONG : WARM_SHORT;
   assign wu_done = wbusy_r & wu_rise & (wcnt_r == wu_len - 17'h00001);

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wbusy_r <= 1'b0;
         wcnt_r <= 17'h00000;
      end else if (wr_osc && wr_data[`DCG_OSC_WUF]) begin
         // a start wins over a completion in the same cycle
         wbusy_r <= 1'b1;
         wcnt_r <= 17'h00000;
      end else if (wu_done) begin
         wbusy_r <= 1'b0;
      end else if (wbusy_r && wu_rise) begin
         wcnt_r <= wcnt_r + 17'h00001;
      end
   end

   // ------------------------------------------------------------
   // halt state machine
   // ------------------------------------------------------------
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_NORMAL: begin
            if (halt_req) begin
               case (wd_r[3:2])
                  `DCG_HM_STOP: st_nxt = ST_STOP;
                  `DCG_HM_DEEP_IDLE: st_nxt = ST_DEEP;
                  `DCG_HM_LIGHT_IDLE: st_nxt = ST_LIGHT;
                  default: st_nxt = ST_RUN;
               endcase
            end
         end
         ST_RUN, ST_LIGHT, ST_DEEP, ST_STOP: begin
            if (halt_release) begin
               st_nxt = ST_NORMAL;
            end
         end
         default: st_nxt = ST_NORMAL;
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= ST_NORMAL;
         cpu_halted <= 1'b0;
         io_stop <= 1'b0;
         adc_stop <= 1'b0;
         rtc_stop <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cpu_halted <= ~st_nxt[0];
         io_stop <= st_nxt[3] | st_nxt[4];
         adc_stop <= st_nxt[2] | st_nxt[3] | st_nxt[4];
         rtc_stop <= st_nxt[4];
      end
   end

   // ------------------------------------------------------------
   // pins and watchdog fields
   // ------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         clk_pin_o <= 1'b1;
         clk_pin_oe <= 1'b1;
         ale_o <= 1'b0;
         ale_oe <= 1'b0;
         system_clock_out_pin <= 1'b0;
         system_clock_out_pin_oe <= 1'b0;
         watchdog_enable <= 1'b1;
         watchdog_period <= 2'h0;
         watchdog_to_reset_link <= 1'b0;
         drive_in_stop <= 1'b0;
      end else begin
         clk_pin_o <= clkout_r;
         clk_pin_oe <= ck_r[`DCG_CK_CLKEN];
         ale_o <= ale_src;
         ale_oe <= ck_r[`DCG_CK_LATCH_STROBE_ENABLE];
         system_clock_out_pin <= ck_r[`DCG_CK_CLKOUT_SOURCE_SELECT] ?
                                 state_clk : base_clk;
         system_clock_out_pin_oe <= ck_r[`DCG_CK_CLKOUT_ENABLE];
         watchdog_enable <= wd_r[`DCG_WD_EN];
         watchdog_period <= wd_r[6:5];
         watchdog_to_reset_link <= wd_r[`DCG_WD_RSTLNK];
         drive_in_stop <= wd_r[`DCG_WD_DRV];
      end
   end

   // reset hold length is the far side's duty
   // warm-up use with watchdog off is software's duty

endmodule // dcg_ctrl

//--- test/dcg_osc_model.sv
// oscillator models that feed the high and low frequency clock inputs
`timescale 1ns/1ns
module dcg_osc_model #(
   parameter int FC_HALF = 100, // high osc half period, ns
   parameter int FS_HALF = 260 // low osc half period, ns
) (
   input wire logic hi_run, // high osc enabled
   input wire logic lo_run, // low osc enabled
   output logic fc_pin, // high osc output
   output logic fs_pin // low osc output
);
   // a stopped oscillator stands still, so a missing enable shows up;
   // 3 ns of phase keeps every edge off the sampling clock edge
   initial begin
      fc_pin = 1'h0;
      #3;
      forever begin
         #FC_HALF;
         if (hi_run === 1'h1) begin
            fc_pin = ~fc_pin;
         end
      end
   end
   // low oscillator, phase unrelated to the high one
   initial begin
      fs_pin = 1'h0;
      #3;
      forever begin
         #FS_HALF;
         if (lo_run === 1'h1) begin
            fs_pin = ~fs_pin;
         end
      end
   end
endmodule // dcg_osc_model

//--- test/dcg_ctrl_asserts.sv
// port assertions of the clock controller
`timescale 1ns/1ns
module dcg_ctrl_asserts (
   input wire logic mclk, // clock
   input wire logic rst, // reset
   input wire logic [7:0] addr, // address
   input wire logic [7:0] wr_data, // write data
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   input wire logic [7:0] rd_data, // read data
   input wire logic ale_src, // latch strobe in
   input wire logic hi_osc_run, // high osc enable
   input wire logic lo_osc_run, // low osc enable
   input wire logic state_clk, // state clock
   input wire logic clk_pin_o, // clock pin value
   input wire logic clk_pin_oe, // clock pin enable
   input wire logic ale_o, // latch strobe value
   input wire logic ale_oe, // latch strobe enable
   input wire logic rtc_stop, // rtc stopped
   input wire logic watchdog_enable, // watchdog enable
   input wire logic [1:0] watchdog_period // watchdog period
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // register read-back and copies
   property p_gear_fill;
      rd_en && addr == 8'h6F |=> rd_data[7:4] == 4'hF;
   endproperty
   a_gear_fill: assert property (p_gear_fill)
      else $error("gear register upper bits not all set");
   property p_wd_copy;
      wr_en && addr == 8'h5C |=> ##1 watchdog_enable == $past(wr_data[7], 2)
         && watchdog_period == $past(wr_data[6:5], 2);
   endproperty
   a_wd_copy: assert property (p_wd_copy)
      else $error("watchdog fields not copied");
   // reset state of pins and oscillators
   property p_reset_pins;
      disable iff (1'h0) rst |-> clk_pin_o && clk_pin_oe && !ale_oe;
   endproperty
   a_reset_pins: assert property (p_reset_pins)
      else $error("clock or strobe pin wrong during reset");
   property p_osc_reset;
      $past(rst) |-> hi_osc_run && !lo_osc_run;
   endproperty
   a_osc_reset: assert property (p_osc_reset)
      else $error("oscillator enables wrong after reset");
   // clock shapes: no runt pulses on state clock or pin; oscillators off in STOP; strobe passes
   property p_state_half;
      $changed(state_clk) |=> $stable(state_clk)[*3];
   endproperty
   a_state_half: assert property (p_state_half)
      else $error("state clock pulse too short");
   property p_clk_div;
      $changed(clk_pin_o) && $past(clk_pin_oe) && clk_pin_oe
         |=> $stable(clk_pin_o)[*8];
   endproperty
   a_clk_div: assert property (p_clk_div)
      else $error("clock pin half period too short");
   property p_stop_osc;
      $rose(rtc_stop) |-> ##[0:2] !hi_osc_run && !lo_osc_run;
   endproperty
   a_stop_osc: assert property (p_stop_osc)
      else $error("oscillators still enabled in stop");
   property p_ale_pass;
      ale_oe |-> ale_o == $past(ale_src);
   endproperty
   a_ale_pass: assert property (p_ale_pass)
      else $error("latch strobe pin not passing strobe");
endmodule // dcg_ctrl_asserts
bind dcg_ctrl dcg_ctrl_asserts dcg_ctrl_asserts_i (.mclk(mclk), .rst(rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .ale_src(ale_src), .hi_osc_run(hi_osc_run),
   .lo_osc_run(lo_osc_run), .state_clk(state_clk), .clk_pin_o(clk_pin_o),
   .clk_pin_oe(clk_pin_oe), .ale_o(ale_o), .ale_oe(ale_oe),
   .rtc_stop(rtc_stop), .watchdog_enable(watchdog_enable),
   .watchdog_period(watchdog_period));

//--- test/dual_clock_gear_standby_ctrl_tb.sv
// self-checking bench of the clock controller
`timescale 1ns/1ns
module dual_clock_gear_standby_ctrl_tb;
   localparam int WS = 8; // short warm-up, shortened
   localparam int WL = 16; // long warm-up, shortened
   logic mclk = 1'h0;
   logic rst = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'h0, rd_en = 1'h0, ale_src = 1'h0;
   logic halt_req = 1'h0, halt_release = 1'h0;
   logic [7:0] rd_data, v;
   logic fc_pin, fs_pin, hi_osc_run, lo_osc_run, base_clk, state_clk;
   logic presc_clk, system_clock_out_pin, system_clock_out_pin_oe, clk_pin_o, clk_pin_oe;
   logic ale_o, ale_oe, cpu_halted, io_stop, adc_stop, rtc_stop;
   logic watchdog_enable, watchdog_to_reset_link, drive_in_stop;
   logic [1:0] watchdog_period;
   logic [2:0] sel = 3'h0;
   logic [7:0] hexp [4] = '{8'h18, 8'h0F, 8'h2E, 8'h2A};
   int errors = 0;
   int compares = 0;
   int p, i;
   wire msig = (sel == 3'h0) ? state_clk : (sel == 3'h1) ? base_clk :
      (sel == 3'h2) ? system_clock_out_pin : (sel == 3'h3) ? clk_pin_o :
      presc_clk;
   // clock and a latch strobe that toggles every cycle
   always #20 mclk = ~mclk;
   always @(posedge mclk) ale_src <= ~ale_src;
   dcg_osc_model dcg_osc_model_i (.hi_run(hi_osc_run), .lo_run(lo_osc_run),
      .fc_pin(fc_pin), .fs_pin(fs_pin));
   dcg_ctrl #(.WARM_SHORT(17'(WS)), .WARM_LONG(17'(WL))) dcg_ctrl_i (
      .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fc_pin(fc_pin),
      .fs_pin(fs_pin), .halt_req(halt_req), .halt_release(halt_release),
      .ale_src(ale_src), .hi_osc_run(hi_osc_run), .lo_osc_run(lo_osc_run),
      .base_clk(base_clk), .state_clk(state_clk), .presc_clk(presc_clk),
      .system_clock_out_pin(system_clock_out_pin), .system_clock_out_pin_oe(system_clock_out_pin_oe),
      .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe), .ale_o(ale_o),
      .ale_oe(ale_oe), .cpu_halted(cpu_halted), .io_stop(io_stop),
      .adc_stop(adc_stop), .rtc_stop(rtc_stop),
      .watchdog_enable(watchdog_enable), .watchdog_period(watchdog_period),
      .watchdog_to_reset_link(watchdog_to_reset_link),
      .drive_in_stop(drive_in_stop));
   // ---------------------------------------------------------
   // verdict, compares and bus cycles
   // ---------------------------------------------------------
   task automatic conclude;
      if (errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkp(input int c, input int lo, input int hi);
      compares++;
      if (c < lo || c > hi) begin
         errors++;
         $display("MISMATCH %0t count %0d not in %0d..%0d", $time, c, lo, hi);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'h1;
      @(posedge mclk);
      wr_en <= 1'h0;
   endtask
   task automatic rdv(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge mclk);
      rd_en <= 1'h0;
      #1;
      d = rd_data;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rdv(a, d);
      chk(d, exp);
   endtask
   // cycles to the next rising edge of the selected clock
   task automatic rise(output int c);
      logic q;
      c = 0;
      q = 1'h1;
      repeat (2000) begin
         @(posedge mclk);
         #1;
         c++;
         if (q === 1'h0 && msig === 1'h1) return;
         q = msig;
      end
      errors++;
      $display("MISMATCH %0t clock edge missing", $time);
      conclude;
   endtask
   task automatic per(input logic [2:0] s, output int c);
      sel = s;
      rise(c);
      rise(c);
      rise(c);
   endtask
   // start a warm-up and time it by polling the busy flag
   task automatic warm(input int w);
      time t0;
      logic [7:0] d;
      wr(8'h6E, 8'hE4);
      rd(8'h6E, 8'hE4);
      t0 = $time;
      d = 8'h04;
      for (int k = 0; k < 300 && d[2] !== 1'h0; k++) rdv(8'h6E, d);
      chkp(int'(($time - t0) / 40), w * 13 - 13, w * 13 + 20);
   endtask
   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial begin
      rst <= 1'h1;
      repeat (8) @(posedge mclk);
      rst <= 1'h0;
      rd(8'h6E, 8'hA0);
      rd(8'h6F, 8'hF4);
      rd(8'h6D, 8'h00);
      rd(8'h5C, 8'h80);
      rd(8'h10, 8'h00);
      wr(8'h6F, 8'h07);
      rd(8'h6F, 8'hF4);
      wr(8'h6E, 8'hA3);
      rd(8'h6E, 8'hA0);
      wr(8'h6E, 8'hA1);
      rd(8'h6E, 8'hA1);
      wr(8'h6E, 8'hA2);
      rd(8'h6E, 8'hA2);
      per(3'h4, p);
      chkp(p, 78, 82);
      for (i = 4; i >= 0; i--) begin
         wr(8'h6F, 8'(i));
         per(3'h0, p);
         chkp(p, 10 * (1 << i) - 2, 10 * (1 << i) + 2);
      end
      wr(8'h6D, 8'h0F);
      rd(8'h6D, 8'h0F);
      per(3'h2, p);
      chkp(p, 8, 12);
      per(3'h3, p);
      chkp(p, 18, 22);
      wr(8'h6D, 8'h07);
      per(3'h2, p);
      chkp(p, 3, 7);
      chk({5'h0, system_clock_out_pin_oe, ale_oe, clk_pin_oe}, 8'h07);
      wr(8'h5C, 8'h63);
      repeat (2) @(posedge mclk);
      #1;
      chk({3'h0, watchdog_enable, watchdog_period, watchdog_to_reset_link,
         drive_in_stop}, 8'h0F);
      wr(8'h5C, 8'h10);
      wr(8'h6E, 8'hE0);
      warm(WL);
      wr(8'h5C, 8'h00);
      warm(WS);
      wr(8'h6E, 8'hE0);
      rd(8'h6E, 8'hE0);
      wr(8'h6F, 8'h0C);
      per(3'h0, p);
      chkp(p, 24, 28);
      wr(8'h6E, 8'h20);
      repeat (3) @(posedge mclk);
      chk({6'h0, hi_osc_run, lo_osc_run}, 8'h01);
      for (i = 0; i < 4; i++) begin
         wr(8'h5C, 8'(i << 2));
         halt_req <= 1'h1;
         @(posedge mclk);
         halt_req <= 1'h0;
         repeat (3) @(posedge mclk);
         #1;
         chk({2'h0, hi_osc_run, lo_osc_run, cpu_halted, io_stop, adc_stop,
            rtc_stop}, hexp[i]);
         halt_release <= 1'h1;
         @(posedge mclk);
         halt_release <= 1'h0;
         repeat (3) @(posedge mclk);
      end
      rd(8'h6E, 8'hA0);
      rd(8'h6F, 8'hF4);
      conclude;
   end
endmodule // dual_clock_gear_standby_ctrl_tb
